// ---- rtl/hbfm_pkg.sv ----
// constants and types for the half-bridge fault manager
// Overview of operation
// - desat pulses shorter than filter ignored
// - blank desat detection after each turn-on
// - desat after blanking registers fault, turns off
// - soft shutdown: driver hi-z, soft pulldown on
// - hold sync line low during soft shutdown
// - soft shutdown end drives fault line low
// - desat fault latched until fault clear
// - soft shutdown masks undervoltage and external shutdown
// - desat monitor active only while output on
// - sync line is shared wired-low peer link
// - sync line low freezes both outputs
// - desat keeps priority while frozen
// - fault line low forces hard shutdown
// - low-side undervoltage pulls fault line, unlatched
// - external shutdown unlatched, clear has no effect
// - both inputs on turns both outputs off
// - fault clear releases line, outputs follow
// - opposite input ignored during soft shutdown
// - boost stage only for initial on interval
// - high-side undervoltage latches high output off
// - dead time between one off, other on
package hbfm_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned FILTER_NS = 500;
    localparam int unsigned BLANK_NS = 3000;
    localparam int unsigned SOFT_NS = 9600;
    localparam int unsigned BOOST_NS = 400;
    localparam int unsigned DEAD_NS = 330;
    localparam int unsigned CLK_NS = 1_000_000_000 / CLK_HZ;
    // least times round up
    localparam int unsigned FILTER_CYC = (FILTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned SOFT_CYC = (SOFT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned DEAD_CYC = (DEAD_NS + CLK_NS - 1) / CLK_NS;
    // longest time rounds down
    localparam int unsigned BOOST_CYC = BOOST_NS / CLK_NS;
    localparam int CNT_W = 11;
    localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
    localparam int NSIDE = 2;
    localparam int SIDE_HI = 1;
    localparam int SIDE_LO = 0;
    typedef enum logic [1:0] {
        HBFM_RUN = 2'b00,
        HBFM_SOFT = 2'b01,
        HBFM_LATCHED = 2'b11
    } hbfm_state_e;
endpackage

// ---- rtl/hbfm_core.sv ----
// half-bridge protection, soft shutdown, freeze and drive sequencing
module hbfm_core (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // controller commands
    input wire logic high_in_i,
    input wire logic low_in_i,
    input wire logic fault_clear_input_i,
    // supply monitors
    input wire logic low_supply_undervoltage_i,
    input wire logic high_supply_undervoltage_i,
    // desat comparators
    input wire logic high_side_desat_sense_i,
    input wire logic low_side_desat_sense_i,
    // shared active-low lines, pin level in, pull-down out
    input wire logic sync_fault_line_i,
    output logic sync_fault_line_o,
    output logic sync_fault_line_oe_o,
    input wire logic fault_shutdown_line_i,
    output logic fault_shutdown_line_o,
    output logic fault_shutdown_line_oe_o,
    // output stages: [1] high side, [0] low side
    output logic [hbfm_pkg::NSIDE-1:0] primary_drive_o,
    output logic [hbfm_pkg::NSIDE-1:0] boost_drive_o,
    output logic [hbfm_pkg::NSIDE-1:0] driver_hiz_o,
    output logic [hbfm_pkg::NSIDE-1:0] soft_pulldown_output_o
);
    import hbfm_pkg::*;

    localparam int NSYNC = 7;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] meta_q;
    logic [NSYNC-1:0] sync_q;
    logic hin_s, lin_s, clr_s, uvl_s, uvh_s, sfl_s, fsl_s;
    logic [NSIDE-1:0] desat_s;

    assign raw_in = {high_in_i, low_in_i, fault_clear_input_i, low_supply_undervoltage_i,
                     high_supply_undervoltage_i, sync_fault_line_i, fault_shutdown_line_i};

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            // lines idle high, everything else idle low
            meta_q <= 7'h03;
            sync_q <= 7'h03;
        end else begin
            meta_q <= raw_in;
            sync_q <= meta_q;
        end
    end

    assign {hin_s, lin_s, clr_s, uvl_s, uvh_s, sfl_s, fsl_s} = sync_q;

    logic [NSIDE-1:0] desat_meta_q;
    logic [NSIDE-1:0] desat_sync_q;
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            desat_meta_q <= 2'h0;
            desat_sync_q <= 2'h0;
        end else begin
            desat_meta_q <= {high_side_desat_sense_i, low_side_desat_sense_i};
            desat_sync_q <= desat_meta_q;
        end
    end
    assign desat_s = desat_sync_q;

    hbfm_state_e state_q;
    logic soft_side_q;
    logic [CNT_W-1:0] soft_cnt_q;
    logic [NSIDE-1:0] out_q;
    logic [NSIDE-1:0] cmd;
    logic [NSIDE-1:0] want;
    logic [NSIDE-1:0] desat_evt;
    logic [NSIDE-1:0] filt_ok;
    logic [NSIDE-1:0] blank_done;
    logic sync_drive_q, fault_drive_q;
    logic freeze, hard_sd, in_soft, soft_last;
    logic uvh_latch_q, hin_prev_q;
    logic [CNT_W-1:0] dead_cnt_q;

    assign in_soft = (state_q == HBFM_SOFT);
    // last soft cycle: stage and sync line must release together
    assign soft_last = in_soft && (soft_cnt_q == CNT_W'(SOFT_CYC - 1));
    // line low from anyone freezes; our own drive is on the wire too
    assign freeze = !sfl_s || sync_drive_q;
    // soft shutdown masks external shutdown and undervoltage
    assign hard_sd = !in_soft && (!fsl_s || uvl_s || state_q == HBFM_LATCHED);

    // per-side filter and blanking counters
    for (genvar s = 0; s < NSIDE; s++) begin : g_side
        logic [CNT_W-1:0] filt_q;
        logic [CNT_W-1:0] blank_q;
        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                filt_q <= CNT_ZERO;
            end else if (!desat_s[s] || !out_q[s]) begin
                filt_q <= CNT_ZERO;
            end else if (filt_q != CNT_W'(FILTER_CYC)) begin
                filt_q <= filt_q + CNT_ONE;
            end
        end
        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                blank_q <= CNT_ZERO;
            end else if (!out_q[s]) begin
                blank_q <= CNT_ZERO;
            end else if (blank_q != CNT_W'(BLANK_CYC)) begin
                blank_q <= blank_q + CNT_ONE;
            end
        end
        assign filt_ok[s] = (filt_q == CNT_W'(FILTER_CYC));
        assign blank_done[s] = (blank_q == CNT_W'(BLANK_CYC));
        // only valid while on; freeze does not mask it
        assign desat_evt[s] = filt_ok[s] && blank_done[s] && out_q[s];

        // boost stage counter
        logic [CNT_W-1:0] boost_q;
        always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
                boost_q <= CNT_ZERO;
                boost_drive_o[s] <= 1'b0;
            end else if (!out_q[s] || in_soft || hard_sd) begin
                boost_q <= CNT_ZERO;
                boost_drive_o[s] <= 1'b0;
            end else if (boost_q != CNT_W'(BOOST_CYC)) begin
                boost_q <= boost_q + CNT_ONE;
                boost_drive_o[s] <= (boost_q + CNT_ONE) != CNT_W'(BOOST_CYC);
            end else begin
                boost_drive_o[s] <= 1'b0;
            end
        end
    end

    // fault sequencing
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= HBFM_RUN;
            soft_side_q <= 1'b0;
            soft_cnt_q <= CNT_ZERO;
        end else begin
            case (state_q)
                HBFM_RUN, HBFM_LATCHED: begin
                    // desat has top priority, even when frozen or latched
                    if (|desat_evt) begin
                        state_q <= HBFM_SOFT;
                        soft_side_q <= desat_evt[SIDE_HI];
                        soft_cnt_q <= CNT_ZERO;
                    end else if (state_q == HBFM_LATCHED && clr_s) begin
                        state_q <= HBFM_RUN;
                    end
                end
                HBFM_SOFT: begin
                    if (soft_cnt_q == CNT_W'(SOFT_CYC - 1)) begin
                        state_q <= HBFM_LATCHED;
                    end else begin
                        soft_cnt_q <= soft_cnt_q + CNT_ONE;
                    end
                end
                default: state_q <= HBFM_RUN;
            endcase
        end
    end

    // high-side undervoltage latch, needs a new rising edge after recovery
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            uvh_latch_q <= 1'b0;
            hin_prev_q <= 1'b0;
        end else begin
            hin_prev_q <= hin_s;
            if (uvh_s) begin
                uvh_latch_q <= 1'b1;
            end else if (hin_s && !hin_prev_q) begin
                uvh_latch_q <= 1'b0;
            end
        end
    end

    // anti shoot-through on the command pair
    always_comb begin
        cmd = {hin_s, lin_s};
        if (hin_s && lin_s) begin
            cmd = 2'h0;
        end
        if (uvh_latch_q || uvh_s) begin
            cmd[SIDE_HI] = 1'b0;
        end
    end

    // dead time: a side may only turn on after the other has been off for the dead time
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            dead_cnt_q <= CNT_ZERO;
        end else if (|out_q) begin
            dead_cnt_q <= CNT_ZERO;
        end else if (dead_cnt_q != CNT_W'(DEAD_CYC)) begin
            dead_cnt_q <= dead_cnt_q + CNT_ONE;
        end
    end

    always_comb begin
        want = out_q;
        if (cmd != out_q) begin
            want = cmd & out_q;
            if (out_q == 2'h0 && dead_cnt_q == CNT_W'(DEAD_CYC)) begin
                want = cmd;
            end
        end
    end

    // logical on state of each output
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            out_q <= 2'h0;
        end else if (in_soft || |desat_evt) begin
            out_q <= 2'h0;
        end else if (hard_sd) begin
            out_q <= 2'h0;
        end else if (freeze) begin
            out_q <= out_q;
        end else begin
            out_q <= want;
        end
    end

    // pin stages
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            primary_drive_o <= 2'h0;
            driver_hiz_o <= 2'h0;
            soft_pulldown_output_o <= 2'h0;
        end else begin
            for (int s = 0; s < NSIDE; s++) begin
                if (|desat_evt ? desat_evt[s] : (in_soft && !soft_last && soft_side_q == (s == SIDE_HI))) begin
                    primary_drive_o[s] <= 1'b0;
                    driver_hiz_o[s] <= 1'b1;
                    soft_pulldown_output_o[s] <= 1'b1;
                end else begin
                    primary_drive_o[s] <= out_q[s] && !in_soft && !hard_sd;
                    driver_hiz_o[s] <= 1'b0;
                    soft_pulldown_output_o[s] <= 1'b0;
                end
            end
        end
    end

    // shared line pull-downs; the low level is always 0, enable drives it
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sync_drive_q <= 1'b0;
            fault_drive_q <= 1'b0;
        end else begin
            sync_drive_q <= (|desat_evt) || (in_soft && soft_cnt_q != CNT_W'(SOFT_CYC - 1));
            fault_drive_q <= (state_q == HBFM_LATCHED && !clr_s && !(|desat_evt))
                             || (in_soft && soft_cnt_q == CNT_W'(SOFT_CYC - 1))
                             || (uvl_s && !in_soft);
        end
    end

    assign sync_fault_line_o = 1'b0;
    assign sync_fault_line_oe_o = sync_drive_q;
    assign fault_shutdown_line_o = 1'b0;
    assign fault_shutdown_line_oe_o = fault_drive_q;
endmodule

// ---- verification/hbfm_core_monitor.sv ----
// concurrent checks on the fault manager ports
module hbfm_core_monitor
    import hbfm_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // watched inputs
    input wire logic fault_clear_input_i,
    input wire logic low_supply_undervoltage_i,
    input wire logic sync_fault_line_i,
    input wire logic fault_shutdown_line_i,
    // watched outputs
    input wire logic sync_fault_line_oe_o,
    input wire logic fault_shutdown_line_oe_o,
    input wire logic [hbfm_pkg::NSIDE-1:0] primary_drive_o,
    input wire logic [hbfm_pkg::NSIDE-1:0] boost_drive_o,
    input wire logic [hbfm_pkg::NSIDE-1:0] driver_hiz_o,
    input wire logic [hbfm_pkg::NSIDE-1:0] soft_pulldown_output_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    logic [CNT_W-1:0] soft_q;
    logic [CNT_W-1:0] boost_q;
    // run lengths of soft shutdown and boost
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            soft_q <= CNT_ZERO;
            boost_q <= CNT_ZERO;
        end else begin
            soft_q <= sync_fault_line_oe_o ? soft_q + CNT_ONE : CNT_ZERO;
            boost_q <= (|boost_drive_o) ? boost_q + CNT_ONE : CNT_ZERO;
        end
    end
    chk_no_shoot: assert property (primary_drive_o != 2'h3)
        else $error("both outputs on");
    chk_soft_stage: assert property (driver_hiz_o == soft_pulldown_output_o && (driver_hiz_o & primary_drive_o) == 2'h0)
        else $error("soft stage mismatch");
    chk_soft_sync: assert property (|driver_hiz_o |-> sync_fault_line_oe_o)
        else $error("sync line not held in soft shutdown");
    chk_soft_span: assert property ($fell(sync_fault_line_oe_o) |-> soft_q >= SOFT_CYC - 1 && soft_q <= SOFT_CYC + 1)
        else $error("soft shutdown length wrong");
    chk_fault_follow: assert property ($fell(sync_fault_line_oe_o) |-> fault_shutdown_line_oe_o)
        else $error("no fault after soft shutdown");
    chk_fault_latch: assert property ($fell(sync_fault_line_oe_o) ##1 (!fault_clear_input_i)[*5] |-> fault_shutdown_line_oe_o)
        else $error("fault not latched");
    chk_hard_off: assert property ((!fault_shutdown_line_i && !sync_fault_line_oe_o)[*5] |-> primary_drive_o == 2'h0)
        else $error("output on during shutdown");
    chk_uv_pull: assert property ((low_supply_undervoltage_i && !sync_fault_line_oe_o)[*4] |-> fault_shutdown_line_oe_o)
        else $error("undervoltage not signalled");
    chk_freeze_hold: assert property ((!sync_fault_line_i && $stable(driver_hiz_o))[*4] |-> $stable(primary_drive_o))
        else $error("outputs moved while frozen");
    chk_boost_len: assert property (boost_q <= BOOST_CYC && (boost_drive_o & ~primary_drive_o) == 2'h0)
        else $error("boost stage misuse");
    cover property ($rose(sync_fault_line_oe_o));
    cover property ($fell(fault_shutdown_line_oe_o));
    cover property (!sync_fault_line_i && primary_drive_o != 2'h0);
endmodule

bind hbfm_core hbfm_core_monitor mon (.*);

// ---- verification/hbfm_peer_model.sv ----
// peer driver and controller on the shared active-low lines
module hbfm_peer_model (
    // pulls commanded by the bench
    input wire logic pull_sync_i,
    input wire logic pull_fault_i,
    // pull-down enables of the device
    input wire logic sync_oe_i,
    input wire logic fault_oe_i,
    // resolved levels, pulled up when idle
    output logic sync_line_o,
    output logic fault_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign sync_line_o = !(pull_sync_i || sync_oe_i);
    assign fault_line_o = !(pull_fault_i || fault_oe_i);
endmodule

// ---- verification/hbfm_core_bench.sv ----
// self-checking bench for the half-bridge fault manager
module hbfm_core_bench;
    import hbfm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_i, reset_i, hin, lin, clr, luv, huv, high_side_desat_sense, low_side_desat_sense, pull_s, pull_f, sync_pin, flt_pin, soe, foe;
    logic [1:0] pri, boost, hiz, pd;
    logic [7:0] obs;
    logic [7:0] exp_q[$];
    logic [31:0] r;
    int due_q[$];
    int cyc = 0;
    int mismatches = 0;
    int samples_checked = 0;
    int seed = 32'h0FA182A3;
    assign obs = {pri, hiz, pd, soe, foe};
    hbfm_core uut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .high_in_i(hin), .low_in_i(lin),
        .fault_clear_input_i(clr), .low_supply_undervoltage_i(luv), .high_supply_undervoltage_i(huv),
        .high_side_desat_sense_i(high_side_desat_sense), .low_side_desat_sense_i(low_side_desat_sense), .sync_fault_line_i(sync_pin),
        .sync_fault_line_o(), .sync_fault_line_oe_o(soe), .fault_shutdown_line_i(flt_pin),
        .fault_shutdown_line_o(), .fault_shutdown_line_oe_o(foe), .primary_drive_o(pri),
        .boost_drive_o(boost), .driver_hiz_o(hiz), .soft_pulldown_output_o(pd));
    hbfm_peer_model peer (.pull_sync_i(pull_s), .pull_fault_i(pull_f), .sync_oe_i(soe),
        .fault_oe_i(foe), .sync_line_o(sync_pin), .fault_line_o(flt_pin));
    initial begin
        sys_clk_i = 0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic note(input int dly, input logic [7:0] v);
        due_q.push_back(cyc + dly);
        exp_q.push_back(v);
    endtask
    task automatic cmp_out(input logic [7:0] e);
        samples_checked++;
        if (obs !== e) begin
            mismatches++;
            $display("[FAIL] %0t outputs %b expected %b", $time, obs, e);
        end
    endtask
    int boost_run = 0;
    task automatic cmp_boost(input int n);
        samples_checked++;
        if (n != BOOST_CYC - 1) begin
            mismatches++;
            $display("[FAIL] %0t boost lasted %0d cycles", $time, n);
        end
    endtask
    // boost length, only when it ends while the high output stays on
    always @(posedge sys_clk_i) begin
        if (boost[1] === 1'b1) begin
            boost_run <= boost_run + 1;
        end else if (boost_run != 0) begin
            if (pri[1] === 1'b1) begin
                cmp_boost(boost_run);
            end
            boost_run <= 0;
        end
    end
    task automatic go(input int n);
        repeat (n) @(posedge sys_clk_i);
    endtask
    // bounded wait on the sync pull-down enable
    task automatic wait_soe(input logic v);
        int n;
        n = 0;
        while (soe !== v && n < 2000) begin
            @(posedge sys_clk_i);
            n++;
        end
        if (n == 2000) begin
            mismatches++;
            $display("[FAIL] %0t sync enable never reached %b", $time, v);
        end
    endtask
    // scoreboard and hang guard
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (due_q.size() > 0 && due_q[0] == cyc) begin
            cmp_out(exp_q.pop_front());
            void'(due_q.pop_front());
        end
        if (cyc == 8000) begin
            mismatches++;
            wrap_up();
        end
    end
    initial begin
        {reset_i, hin, lin, clr, luv, huv, high_side_desat_sense, low_side_desat_sense, pull_s, pull_f} = 10'h200;
        go(10);
        reset_i <= 0;
        go(2);
        for (int i = 0; i < 12; i++) begin
            r = $random(seed);
            hin <= r[1];
            lin <= r[0];
            note(45, {(r[1] & r[0]) ? 2'h0 : r[1:0], 6'h00});
            go(50);
        end
        $display("end of command test");
        hin <= 1;
        lin <= 0;
        go(45);
        pull_f <= 1;
        clr <= 1;
        note(10, 8'h00);
        go(20);
        {pull_f, clr} <= 2'h0;
        note(45, 8'h80);
        go(50);
        luv <= 1;
        note(10, 8'h01);
        go(20);
        luv <= 0;
        note(45, 8'h80);
        go(350);
        $display("end of shutdown test");
        {high_side_desat_sense, low_side_desat_sense} <= 2'h3;
        go(30);
        high_side_desat_sense <= 0;
        note(60, 8'h80);
        go(400);
        note(1, 8'h80);
        low_side_desat_sense <= 0;
        go(5);
        hin <= 0;
        go(10);
        hin <= 1;
        high_side_desat_sense <= 1;
        note(200, 8'h80);
        wait_soe(1);
        {lin, luv, pull_f} <= 3'h7;
        note(50, 8'h2A);
        go(60);
        {luv, pull_f} <= 2'h0;
        wait_soe(0);
        note(2, 8'h01);
        {high_side_desat_sense, lin} <= 2'h0;
        go(50);
        note(1, 8'h01);
        go(5);
        clr <= 1;
        go(10);
        clr <= 0;
        note(45, 8'h80);
        go(50);
        $display("end of desat test");
        pull_s <= 1;
        go(5);
        hin <= 0;
        lin <= 1;
        note(40, 8'h80);
        go(45);
        pull_s <= 0;
        note(45, 8'h40);
        go(50);
        {hin, lin} <= 2'h2;
        go(45);
        huv <= 1;
        note(10, 8'h00);
        go(20);
        huv <= 0;
        note(20, 8'h00);
        go(30);
        hin <= 0;
        go(5);
        hin <= 1;
        note(45, 8'h80);
        go(50);
        $display("end of freeze and supply test");
        wrap_up();
    end
endmodule
